// ==== verilog/sync_sampling_regs.vh ====
// Purpose: Constants for the serial-line-synchronised sampling controller.
// Assumes: Clock of 10 MHz; commands arrive already decoded as codes.
// Notes:   Times are kept in their own unit beside the derived cycle counts.
`ifndef SYNC_SAMPLING_REGS_VH
`define SYNC_SAMPLING_REGS_VH
`define CLK_HZ              10000000
`define SCHEME_W            2
`define SCHEME_SERIAL_SYNC  2'h1
`define CMD_W               3
`define CMD_NONE            3'h0
`define CMD_START           3'h1
`define CMD_STOP            3'h2
`define CMD_SLEEP           3'h3
`define CMD_REPORT_CFG      3'h4
`define CMD_CONFIG          3'h5
`define IDLE_TIMEOUT_MIN    2
`define IDLE_TIMEOUT_CYC    (`IDLE_TIMEOUT_MIN * 60 * `CLK_HZ)
`define REC_ADDR_W          8
`define REC_DATA_W          16
`endif

// ==== verilog/record_store.v ====
// Purpose: Small memory that keeps the logged sample records.
// Assumes: One write port and one read port on the same clock.
// Notes:   Read data come out of a register one cycle after the address.
`timescale 1ns/1ps
module record_store
#(
    parameter AW = 8,
    parameter DW = 16
)
(
    input  wire          i_clk,
    input  wire          i_we,
    input  wire [AW-1:0] i_waddr,
    input  wire [DW-1:0] i_wdata,
    input  wire [AW-1:0] i_raddr,
    output reg  [DW-1:0] o_rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge i_clk)
    begin
        if (i_we)
            mem[i_waddr] <= i_wdata;
        o_rdata <= mem[i_raddr];
    end
endmodule

// ==== verilog/serial_sync_sampling_control.v ====
// Purpose: Sequencer for serial-line-synchronised sampling: wake, sample, send, log, sleep.
// Assumes: Commands, sample completion and transmit completion come from other logic; rx pulse
//          and power-good are pins and are synchronised here.
// Notes:   The idle timeout is a parameter so that a simulation can shorten it.
`timescale 1ns/1ps
`include "sync_sampling_regs.vh"

// Overview of operation
// R1 - Armed and asleep, any received character wakes, samples, sends, sleeps.
// R2 - Acquisition scheme value 1 selects one sample per trigger.
// R3 - With logging enabled each synchronised sample is also written to memory.
// R4 - With timestamp enabled date and time are appended to each record; here o_tx_with_time flags sent records only, memory keeps data alone.
// R5 - Without self-launch, host wakes device then starts; device samples once, sleeps.
// R6 - With self-launch, power alone yields one sample, stored, then sleep.
// R7 - Host wakes then stops; device then ignores characters as triggers.
// R8 - Self-launch starts the sequence every power-up; host stops before configuring.
// R9 - Host should send enter-sleep before removing power after configuring.
// R10 - Two minutes without command or sample data forces quiescent sleep.
module serial_sync_sampling_control
#(
    parameter IDLE_CYC = `IDLE_TIMEOUT_CYC,
    parameter AW       = `REC_ADDR_W,
    parameter DW       = `REC_DATA_W
)
(
    input  wire                 I_CLK,
    input  wire                 I_RSTN,
    input  wire                 i_power_good,
    input  wire                 i_rx_char,
    input  wire [`CMD_W-1:0]    i_cmd,
    input  wire                 i_cmd_valid,
    input  wire [`SCHEME_W-1:0] i_acquisition_scheme,
    input  wire                 i_log_to_memory_flag,
    input  wire                 i_append_timestamp_flag,
    input  wire                 i_power_up_self_launch,
    input  wire                 i_sample_done,
    input  wire [DW-1:0]        i_sample_data,
    input  wire                 i_tx_done,
    input  wire [AW-1:0]        i_read_addr,
    output wire                 o_sample_start,
    output wire                 o_tx_start,
    output reg                  o_tx_with_time,
    output reg  [DW-1:0]        o_tx_data,
    output reg                  o_awake,
    output reg                  o_sync_armed,
    output reg  [AW-1:0]        o_log_count,
    output wire [DW-1:0]        o_read_data
);
    // Binary state codes; the log state is visited only for records marked for logging.
    localparam ST_SLEEP  = 3'h0;
    localparam ST_AWAKE  = 3'h1;
    localparam ST_SAMPLE = 3'h2;
    localparam ST_SEND   = 3'h3;
    localparam ST_LOG    = 3'h4;

    reg [2:0]  state;
    reg [2:0]  next_state;
    reg        rx_meta;
    reg        rx_sync;
    reg        rx_prev;
    reg        pg_meta;
    reg        pg_sync;
    reg        pg_prev;
    // Thirty-two bits hold the full two-minute timeout at this clock rate.
    reg [31:0] idle_cnt;
    reg        log_pending;

    // One qualified command decode, shared by the sequencer and the arming logic.
    function is_cmd;
        input              valid;
        input [`CMD_W-1:0] code;
        input [`CMD_W-1:0] want;
        begin
            is_cmd = valid && (code == want);
        end
    endfunction

    wire rx_edge   = rx_sync & ~rx_prev;
    wire power_up  = pg_sync & ~pg_prev;
    wire cmd_start = is_cmd(i_cmd_valid, i_cmd, `CMD_START);
    wire cmd_stop  = is_cmd(i_cmd_valid, i_cmd, `CMD_STOP);
    wire cmd_sleep = is_cmd(i_cmd_valid, i_cmd, `CMD_SLEEP);
    wire sync_mode = (i_acquisition_scheme == `SCHEME_SERIAL_SYNC); // [R2]
    // The timer holds at the limit, so a long wait in the awake state cannot wrap it.
    wire timeout   = (idle_cnt >= IDLE_CYC - 1);
    wire launch    = (state != ST_SAMPLE) && (next_state == ST_SAMPLE);
    wire log_we    = (state == ST_LOG);

    // Both pins cross into the clock domain through two flip-flops; the third stage
    // only serves the rising-edge detect, so a pin held high after reset is taken
    // as one edge, which is what a power-up should look like.
    always @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            rx_meta <= 1'b0;
            rx_sync <= 1'b0;
            rx_prev <= 1'b0;
            pg_meta <= 1'b0;
            pg_sync <= 1'b0;
            pg_prev <= 1'b0;
        end
        else
        begin
            rx_meta <= i_rx_char;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
            pg_meta <= i_power_good;
            pg_sync <= pg_meta;
            pg_prev <= pg_sync;
        end
    end

    // A power-up starts a sequence only when self-launch is set; that is also why the
    // host must stop the sequence before it can reconfigure.
    always @*
    begin
        next_state = state;
        case (state)
            ST_SLEEP:
            begin
                // Commands are not decoded here: a sleeping device wakes only on the line or a power-up.
                if (power_up && i_power_up_self_launch && sync_mode)
                    next_state = ST_SAMPLE; // [R6] [R8]
                else if (rx_edge && o_sync_armed && sync_mode)
                    next_state = ST_SAMPLE; // [R1]
                else if (rx_edge || power_up)
                    next_state = ST_AWAKE;
            end
            ST_AWAKE:
            begin
                // A start outside the serial-sync scheme is ignored; the device stays awake.
                if (cmd_start && sync_mode)
                    next_state = ST_SAMPLE; // [R5]
                else if (cmd_sleep || timeout)
                    next_state = ST_SLEEP; // [R10]
            end
            ST_SAMPLE:
            begin
                // The sensor decides how long a sample takes; nothing here times it out.
                if (i_sample_done)
                    next_state = ST_SEND;
            end
            ST_SEND:
            begin
                // One sample per trigger: after the record leaves, the device sleeps again.
                if (i_tx_done)
                    next_state = log_pending ? ST_LOG : ST_SLEEP;
            end
            ST_LOG:
            begin
                next_state = ST_SLEEP;
            end
            default:
            begin
                // An unused code falls back to sleep.
                next_state = ST_SLEEP;
            end
        endcase
    end

    always @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            state          <= ST_SLEEP;
            o_sync_armed   <= 1'b0;
            o_tx_data      <= {DW{1'b0}};
            o_tx_with_time <= 1'b0;
            o_log_count    <= {AW{1'b0}};
            log_pending    <= 1'b0;
            idle_cnt       <= 32'h0;
            o_awake        <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            // Awake follows the next state so that it rises in the first cycle of a sequence.
            o_awake <= (next_state != ST_SLEEP);
            // Only the awake state times out; any valid command, even an ignored one,
            // restarts the timer.
            if (state != ST_AWAKE || i_cmd_valid)
                idle_cnt <= 32'h0;
            else if (!timeout)
                idle_cnt <= idle_cnt + 32'h1;
            // Arming happens when a sequence is launched, so that a stop which overtakes
            // a running sample is not undone when that sample ends. A stop in the same
            // cycle wins.
            if (cmd_stop)
                o_sync_armed <= 1'b0; // [R7]
            else if (launch)
                o_sync_armed <= 1'b1;
            // Flags travel with the data, so a change during the send affects the next record.
            if (state == ST_SAMPLE && i_sample_done)
            begin
                o_tx_data      <= i_sample_data;
                o_tx_with_time <= i_append_timestamp_flag; // [R4]
                log_pending    <= i_log_to_memory_flag; // [R3]
            end
            // The count wraps after the last address; older records are then overwritten.
            if (log_we)
            begin
                o_log_count <= o_log_count + {{(AW-1){1'b0}}, 1'b1};
                log_pending <= 1'b0;
            end
        end
    end

    // Both strobes are combinational so the sensor and transmitter start in the decision cycle.
    assign o_sample_start = launch;
    assign o_tx_start     = (state == ST_SAMPLE) && i_sample_done;

    // The record is written one cycle after the send ends; the count is the address.
    record_store #(.AW(AW), .DW(DW)) store
    (
        .i_clk   (I_CLK),
        .i_we    (log_we), // [R3]
        .i_waddr (o_log_count),
        .i_wdata (o_tx_data),
        .i_raddr (i_read_addr),
        .o_rdata (o_read_data)
    );
endmodule

// ==== tb/sampling_checker.sv ====
// Purpose: Port assertions for the sampling sequencer.
// Assumes: One clock, reset active low.
// Notes:   Bound from the testbench top file.
`timescale 1ns/1ps
module sampling_checker
(
    input wire        I_CLK,
    input wire        I_RSTN,
    input wire        i_rx_char,
    input wire [2:0]  i_cmd,
    input wire        i_cmd_valid,
    input wire [1:0]  i_acquisition_scheme,
    input wire        i_sample_done,
    input wire [15:0] i_sample_data,
    input wire        i_log_to_memory_flag,
    input wire        i_append_timestamp_flag,
    input wire        o_sample_start,
    input wire        o_tx_start,
    input wire        o_tx_with_time,
    input wire [15:0] o_tx_data,
    input wire        o_awake,
    input wire        o_sync_armed,
    input wire [7:0]  o_log_count
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    a_tx_cause: assert property (o_tx_start |-> i_sample_done && o_awake)
        else $error("tx early");
    a_scheme_gate: assert property (o_sample_start |-> i_acquisition_scheme == 2'h1)
        else $error("sample outside sync scheme");
    a_tx_data: assert property (o_tx_start |=> o_tx_data == $past(i_sample_data))
        else $error("tx data");
    a_time_flag: assert property (o_tx_start |=> o_tx_with_time == $past(i_append_timestamp_flag))
        else $error("time flag");
    a_log_step: assert property ($changed(o_log_count) |-> o_log_count == $past(o_log_count) + 8'h1)
        else $error("log step");
    a_log_gate: assert property ($changed(o_log_count) |-> $past(i_log_to_memory_flag))
        else $error("log gate");
    a_start_wake: assert property (o_sample_start |=> o_awake) else $error("not awake");
    a_stop_clear: assert property ($fell(o_sync_armed) |-> $past(i_cmd_valid && i_cmd == 3'h2))
        else $error("disarm");
    a_rx_trigger: assert property ($rose(i_rx_char) && !o_awake && o_sync_armed
        && i_acquisition_scheme == 2'h1 |-> ##[1:4] o_sample_start)
        else $error("no trigger");
endmodule

// ==== tb/sensor_link_model.sv ====
// Purpose: Sensor and transmitter stand-in beside the sequencer.
// Assumes: Fixed latencies, transmit slower than sampling.
// Notes:   Data lines carry garbage outside the done pulse.
`timescale 1ns/1ps
module sensor_link_model
(
    input  wire        I_CLK,
    input  wire        o_sample_start,
    input  wire        o_tx_start,
    output reg         i_sample_done = 1'h0,
    output reg         i_tx_done = 1'h0,
    output wire [15:0] i_sample_data
);
    reg [15:0] val = 16'h0000;
    reg [3:0]  cnt = 4'h0;
    reg [3:0]  tcnt = 4'h0;
    assign i_sample_data = i_sample_done ? val : ~val;
    always @(posedge I_CLK)
    begin
        i_sample_done <= cnt == 4'h1;
        i_tx_done <= tcnt == 4'h1;
        cnt <= o_sample_start ? 4'h6 : (cnt != 4'h0 ? cnt - 4'h1 : 4'h0);
        tcnt <= o_tx_start ? 4'h9 : (tcnt != 4'h0 ? tcnt - 4'h1 : 4'h0);
        if (o_sample_start)
            val <= val + 16'h1111;
    end
endmodule

// ==== tb/test_serial_sync_sampling_control.sv ====
// Purpose: Directed tests of the sampling sequencer.
// Assumes: Idle timeout shortened to 50 cycles.
// Notes:   Nets share port names so instances connect by name.
`timescale 1ns/1ps
`include "sync_sampling_regs.vh"
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module test_serial_sync_sampling_control;
    reg         I_CLK = 1'h0, I_RSTN = 1'h0, i_power_good = 1'h0, i_rx_char = 1'h0;
    reg         i_cmd_valid = 1'h0, i_log_to_memory_flag = 1'h1, i_append_timestamp_flag = 1'h1;
    reg         i_power_up_self_launch = 1'h0;
    reg  [2:0]  i_cmd = 3'h0;
    reg  [1:0]  i_acquisition_scheme = 2'h1;
    reg  [7:0]  i_read_addr = 8'h00;
    wire        i_sample_done, i_tx_done, o_sample_start, o_tx_start, o_tx_with_time;
    wire        o_awake, o_sync_armed;
    wire [15:0] i_sample_data, o_tx_data, o_read_data;
    wire [7:0]  o_log_count;
    integer     err_total = 0, total_checks = 0, cyc = 0;
    serial_sync_sampling_control #(.IDLE_CYC(50)) i_serial_sync_sampling_control (.*);
    sensor_link_model i_sensor_link_model (.*);
    always #50 I_CLK = ~I_CLK;
    // A hang shows up as a stuck wait; the ceiling is far above the run's need.
    always @(posedge I_CLK)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            end_of_test;
        end
    end
    task end_of_test;
        begin
            $display("checks %0d errors %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task cmd(input [2:0] c);
        begin
            @(posedge I_CLK);
            i_cmd <= c;
            i_cmd_valid <= 1'h1;
            @(posedge I_CLK);
            i_cmd_valid <= 1'h0;
            repeat (2) @(posedge I_CLK);
        end
    endtask
    task rx;
        begin
            @(posedge I_CLK);
            i_rx_char <= 1'h1;
            repeat (4) @(posedge I_CLK);
            i_rx_char <= 1'h0;
            repeat (6) @(posedge I_CLK);
        end
    endtask
    task wait_sleep;
        begin
            repeat (6) @(negedge I_CLK);
            while (o_awake !== 1'h0)
                @(negedge I_CLK);
        end
    endtask
    initial
    begin
        repeat (20) @(posedge I_CLK);
        I_RSTN <= 1'h1;
        i_power_good <= 1'h1;
        rx;
        cmd(`CMD_START);
        wait_sleep;
        `CHK("log", 8'h01, o_log_count)
        `CHK("data", 16'h1111, o_tx_data)
        `CHK("stamp", 1'h1, o_tx_with_time)
        `CHK("armed", 1'h1, o_sync_armed)
        repeat (2) @(posedge I_CLK);
        `CHK("memory", 16'h1111, o_read_data)
        i_log_to_memory_flag <= 1'h0;
        i_append_timestamp_flag <= 1'h0;
        rx;
        wait_sleep;
        `CHK("data", 16'h2222, o_tx_data)
        `CHK("log", 8'h01, o_log_count)
        `CHK("stamp", 1'h0, o_tx_with_time)
        $display("test trigger ends");
        rx;
        cmd(`CMD_STOP);
        wait_sleep;
        `CHK("armed", 1'h0, o_sync_armed)
        rx;
        i_acquisition_scheme <= 2'h2;
        cmd(`CMD_START);
        cmd(`CMD_REPORT_CFG);
        cmd(`CMD_CONFIG);
        repeat (20) @(negedge I_CLK);
        `CHK("awake", 1'h1, o_awake)
        `CHK("data", 16'h3333, o_tx_data)
        repeat (60) @(negedge I_CLK);
        `CHK("awake", 1'h0, o_awake)
        rx;
        cmd(`CMD_SLEEP);
        `CHK("awake", 1'h0, o_awake)
        $display("test stop ends");
        i_acquisition_scheme <= 2'h1;
        i_power_up_self_launch <= 1'h1;
        i_log_to_memory_flag <= 1'h1;
        i_power_good <= 1'h0;
        repeat (5) @(posedge I_CLK);
        i_power_good <= 1'h1;
        wait_sleep;
        `CHK("log", 8'h02, o_log_count)
        `CHK("data", 16'h4444, o_tx_data)
        `CHK("armed", 1'h1, o_sync_armed)
        @(posedge I_CLK);
        i_read_addr <= 8'h01;
        repeat (2) @(negedge I_CLK);
        `CHK("memory", 16'h4444, o_read_data)
        $display("test launch ends");
        end_of_test;
    end
endmodule
bind serial_sync_sampling_control sampling_checker i_sampling_checker (.*);
